// >>> hw/virt_cpu_iface_hyp_regs.sv
// hypervisor-facing control and type registers of the virtual interface
`include "vcpu_hyp_params.svh"

// How it works
// RQ1: control bit 0 holds the virtual group 0 enable, 1 enables.
// RQ2: control register read and write at opc2 111 of the shared encoding.
// RQ3: trap control traps NS EL1 accesses; sysreg enable clear makes EL2 undefined.
// RQ4: type bits 31:29 give priority bits minus one, at least five bits.
// RQ5: type bits 28:26 give preemption bits minus one, at least five.
// RQ6: type bits 25:23 code the identifier width, 000 is 16, 001 is 24.
// RQ7: type bit 22 is one when system error generation is supported.
// RQ8: type bit 21 is one when non-zero affinity level 3 is supported.
// RQ9: type bit 20 is one when direct injection is not supported.
// RQ10: type bit 19 is one when separate deactivate write trapping exists.
// RQ11: type bits 4:0 give list entries minus one, at most sixteen.
// RQ12: type register is read only at opc2 001 of the shared encoding.
// RQ13: type fields are constants, bits 18:5 read zero, reads have no effect.
module virt_cpu_iface_hyp_regs #(
  parameter int PRIO_BITS = 5,
  parameter int PREEMPT_BITS = 5,
  parameter logic [2:0] INTID_CODE = `INTID_CODE_16,
  parameter bit SERROR_GEN = 1'b0,
  parameter bit AFF3_VALID = 1'b0,
  parameter bit NO_DIRECT_INJ = 1'b1,
  parameter bit SEP_DEACT_TRAP = 1'b0,
  parameter int LIST_ENTRIES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access from the core
  input wire vcpu_hyp_pkg::sysreg_req_t req,
  input wire vcpu_hyp_pkg::access_ctx_t ctx,
  // answer to the core
  output vcpu_hyp_pkg::sysreg_rsp_t rsp,
  // control to the interface logic
  output logic virt_grp0_enable
);

  typedef struct packed {
    logic [31:0] vmc;
    vcpu_hyp_pkg::sysreg_rsp_t rsp;
  } state_t;

  state_t state_reg;
  state_t state_next;
  vcpu_hyp_pkg::reg_sel_t sel;
  logic [31:0] type_value;
  logic trap_now;
  logic undef_now;

  // builds the fixed type word; reserved bits stay zero
  function automatic logic [31:0] type_word();
    logic [31:0] w;
    w = 32'h0000_0000; // see RQ13
    w[`TYPE_PRIO_HI:`TYPE_PRIO_LO] = 3'(PRIO_BITS - 1); // see RQ4
    w[`TYPE_PREEMPT_HI:`TYPE_PREEMPT_LO] = 3'(PREEMPT_BITS - 1); // see RQ5
    w[`TYPE_INTID_HI:`TYPE_INTID_LO] = INTID_CODE; // see RQ6
    w[`TYPE_SERROR_BIT] = SERROR_GEN; // see RQ7
    w[`TYPE_AFF3_BIT] = AFF3_VALID; // see RQ8
    w[`TYPE_NODI_BIT] = NO_DIRECT_INJ; // see RQ9
    w[`TYPE_SEPTRAP_BIT] = SEP_DEACT_TRAP; // see RQ10
    w[`TYPE_LIST_HI:`TYPE_LIST_LO] = 5'(LIST_ENTRIES - 1); // see RQ11
    return w;
  endfunction

  sysreg_decode u_decode (
    .req(req),
    .sel(sel)
  );

  assign type_value = type_word();

  // trap beats undefined: a trapped NS EL1 access never reaches the EL2 checks
  assign trap_now = (sel != vcpu_hyp_pkg::SEL_NONE) && ctx.ns_el1 &&
                    ctx.hyp_trap_c12; // see RQ3
  assign undef_now = (sel != vcpu_hyp_pkg::SEL_NONE) && !trap_now &&
                     ((ctx.at_el2 && !ctx.sysreg_enable) || !ctx.at_el2 ||
                      (sel == vcpu_hyp_pkg::SEL_TYPE && req.write)); // see RQ3

  // next state: write only when the access is legal
  always_comb begin
    state_next = state_reg;
    state_next.rsp = '0;
    if (sel != vcpu_hyp_pkg::SEL_NONE) begin
      state_next.rsp.done = 1'b1;
      state_next.rsp.trap = trap_now;
      state_next.rsp.undef = undef_now;
      if (!trap_now && !undef_now) begin
        if (sel == vcpu_hyp_pkg::SEL_VMC) begin
          if (req.write) begin
            // only the group 0 enable lives here; others belong elsewhere
            state_next.vmc[`VMC_GRP0_BIT] =
              req.wdata[`VMC_GRP0_BIT]; // see RQ1, RQ2
          end else begin
            state_next.rsp.rdata = state_reg.vmc; // see RQ2
          end
        end else begin
          state_next.rsp.rdata = type_value; // see RQ12, RQ13
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.vmc <= `VMC_RESET;
      state_reg.rsp <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rsp = state_reg.rsp;
  assign virt_grp0_enable = state_reg.vmc[`VMC_GRP0_BIT]; // see RQ1

  // legal control write; refused ones must leave the enable alone
  logic vmc_wr_ok;
  assign vmc_wr_ok = (sel == vcpu_hyp_pkg::SEL_VMC) && req.write &&
                     !trap_now && !undef_now; // see RQ1, RQ2

  // legal write of the control register reaches the enable next cycle
  a_grp0_write: assert property ( // see RQ1
    @(posedge clk) disable iff (!rst_n)
    vmc_wr_ok |=> virt_grp0_enable == $past(req.wdata[0]))
    else $error("group 0 enable did not take written value");

  // control read returns the enable in bit 0
  a_vmc_read: assert property ( // see RQ2
    @(posedge clk) disable iff (!rst_n)
    sel == vcpu_hyp_pkg::SEL_VMC && !req.write && !trap_now && !undef_now
    |=> rsp.done && rsp.rdata[0] == virt_grp0_enable)
    else $error("control read returned wrong enable");

  // the trap check comes first, so undefined never rides with it
  a_trap_el1: assert property ( // see RQ3
    @(posedge clk) disable iff (!rst_n)
    sel != vcpu_hyp_pkg::SEL_NONE && ctx.ns_el1 && ctx.hyp_trap_c12
    |=> rsp.trap && !rsp.undef)
    else $error("trapped access not reported as trap");

  // hypervisor read with the system register interface off
  a_undef_el2: assert property ( // see RQ3
    @(posedge clk) disable iff (!rst_n)
    sel == vcpu_hyp_pkg::SEL_TYPE && ctx.at_el2 && !ctx.sysreg_enable &&
    !ctx.ns_el1 |=> rsp.undef && $stable(virt_grp0_enable))
    else $error("EL2 read with sysreg disabled not undefined");

  // priority widths never fall below the five-bit floor
  a_type_prio: assert property ( // see RQ4
    @(posedge clk) disable iff (!rst_n)
    rsp.done && !rsp.trap && !rsp.undef && $past(sel) ==
    vcpu_hyp_pkg::SEL_TYPE |-> rsp.rdata[31:29] >= 3'h4 &&
    rsp.rdata[28:26] >= 3'h4)
    else $error("type register priority widths below five bits");

  // reserved bits and the unused top of the identifier code read zero
  a_type_rsvd: assert property ( // see RQ13
    @(posedge clk) disable iff (!rst_n)
    rsp.done && !rsp.undef && !rsp.trap && $past(sel) ==
    vcpu_hyp_pkg::SEL_TYPE |-> rsp.rdata[18:5] == 14'h0000 &&
    rsp.rdata[25:24] == 2'h0)
    else $error("reserved type bits or identifier code not zero");

  // the type word refuses writes and keeps the enable untouched
  a_type_ro: assert property ( // see RQ12
    @(posedge clk) disable iff (!rst_n)
    sel == vcpu_hyp_pkg::SEL_TYPE && req.write
    |=> rsp.done && (rsp.undef || rsp.trap) ##1 $stable(virt_grp0_enable))
    else $error("write to type register not refused");

  // list entry count follows the build parameter
  a_list_count: assert property ( // see RQ11
    @(posedge clk) disable iff (!rst_n)
    $past(sel) == vcpu_hyp_pkg::SEL_TYPE && rsp.done && !rsp.undef &&
    !rsp.trap |-> rsp.rdata[4:0] == 5'(LIST_ENTRIES - 1))
    else $error("list entry count wrong");

  // the priority field matches the built width
  a_type_prio_val: assert property ( // see RQ4
    @(posedge clk) disable iff (!rst_n)
    $past(sel) == vcpu_hyp_pkg::SEL_TYPE && rsp.done && !rsp.undef &&
    !rsp.trap |-> rsp.rdata[31:29] == 3'(PRIO_BITS - 1))
    else $error("type priority field wrong");

  // the preemption field matches the built width
  a_type_preempt: assert property ( // see RQ5
    @(posedge clk) disable iff (!rst_n)
    $past(sel) == vcpu_hyp_pkg::SEL_TYPE && rsp.done && !rsp.undef &&
    !rsp.trap |-> rsp.rdata[28:26] == 3'(PREEMPT_BITS - 1))
    else $error("type preemption field wrong");

  // identifier code is one of the two defined widths, never reserved
  a_type_intid: assert property ( // see RQ6
    @(posedge clk) disable iff (!rst_n)
    $past(sel) == vcpu_hyp_pkg::SEL_TYPE && rsp.done && !rsp.undef &&
    !rsp.trap |-> rsp.rdata[25:23] == INTID_CODE &&
    (INTID_CODE == `INTID_CODE_16 || INTID_CODE == `INTID_CODE_24))
    else $error("type identifier code wrong or reserved");

  // flag bits are fixed by the build, a stuck bit shows here
  a_type_serror: assert property ( // see RQ7
    @(posedge clk) disable iff (!rst_n)
    $past(sel) == vcpu_hyp_pkg::SEL_TYPE && rsp.done && !rsp.undef &&
    !rsp.trap |-> rsp.rdata[`TYPE_SERROR_BIT] == SERROR_GEN)
    else $error("type error generation flag wrong");

  // affinity level 3 support flag
  a_type_aff3: assert property ( // see RQ8
    @(posedge clk) disable iff (!rst_n)
    $past(sel) == vcpu_hyp_pkg::SEL_TYPE && rsp.done && !rsp.undef &&
    !rsp.trap |-> rsp.rdata[`TYPE_AFF3_BIT] == AFF3_VALID)
    else $error("type affinity flag wrong");

  // the flag reads one when direct injection is absent
  a_type_nodi: assert property ( // see RQ9
    @(posedge clk) disable iff (!rst_n)
    $past(sel) == vcpu_hyp_pkg::SEL_TYPE && rsp.done && !rsp.undef &&
    !rsp.trap |-> rsp.rdata[`TYPE_NODI_BIT] == NO_DIRECT_INJ)
    else $error("type direct injection flag wrong");

  // separate deactivate write trapping flag
  a_type_septrap: assert property ( // see RQ10
    @(posedge clk) disable iff (!rst_n)
    $past(sel) == vcpu_hyp_pkg::SEL_TYPE && rsp.done && !rsp.undef &&
    !rsp.trap |-> rsp.rdata[`TYPE_SEPTRAP_BIT] == SEP_DEACT_TRAP)
    else $error("type deactivate trap flag wrong");

  // unimplemented control fields read as zero
  a_vmc_rsvd: assert property ( // see RQ1
    @(posedge clk) disable iff (!rst_n)
    $past(sel) == vcpu_hyp_pkg::SEL_VMC && rsp.done && !rsp.undef &&
    !rsp.trap |-> rsp.rdata[31:1] == 31'h0000_0000)
    else $error("control read shows unimplemented bits");

  // only the enable bit is ever stored
  a_vmc_bits: assert property ( // see RQ1
    @(posedge clk) disable iff (!rst_n)
    state_reg.vmc[31:1] == 31'h0000_0000)
    else $error("control register holds bits above the enable");

  // the enable moves only after a legal control write
  a_enable_cause: assert property ( // see RQ1
    @(posedge clk) disable iff (!rst_n)
    $changed(virt_grp0_enable) |-> $past(vmc_wr_ok))
    else $error("group 0 enable changed without a legal write");

  // every selected access is answered on the next cycle
  a_answer_next: assert property ( // see RQ2
    @(posedge clk) disable iff (!rst_n)
    sel != vcpu_hyp_pkg::SEL_NONE |=> rsp.done)
    else $error("selected access not answered");

  // no answer appears without a selected access before it
  a_answer_cause: assert property ( // see RQ12
    @(posedge clk) disable iff (!rst_n)
    rsp.done |-> $past(sel) != vcpu_hyp_pkg::SEL_NONE)
    else $error("answer without a selected access");

  // between answers the response word is all zero
  a_rsp_idle: assert property ( // see RQ13
    @(posedge clk) disable iff (!rst_n)
    !rsp.done |-> !rsp.trap && !rsp.undef &&
    rsp.rdata == 32'h0000_0000)
    else $error("response not idle between answers");

  // a refused access never leaks register contents
  a_refused_quiet: assert property ( // see RQ3
    @(posedge clk) disable iff (!rst_n)
    rsp.trap || rsp.undef |-> rsp.rdata == 32'h0000_0000)
    else $error("refused access returned data");

  // a refused control write must not touch the enable
  a_refused_hold: assert property ( // see RQ3
    @(posedge clk) disable iff (!rst_n)
    sel == vcpu_hyp_pkg::SEL_VMC && req.write && (trap_now || undef_now)
    |=> $stable(virt_grp0_enable))
    else $error("refused control write changed the enable");

  // untrapped accesses from below the hypervisor are undefined
  a_non_el2_undef: assert property ( // see RQ3
    @(posedge clk) disable iff (!rst_n)
    sel != vcpu_hyp_pkg::SEL_NONE && !ctx.at_el2 && !trap_now
    |=> rsp.undef && !rsp.trap)
    else $error("access from outside EL2 not undefined");

  // reading the type word has no side effects
  a_type_quiet: assert property ( // see RQ13
    @(posedge clk) disable iff (!rst_n)
    sel == vcpu_hyp_pkg::SEL_TYPE |=> $stable(virt_grp0_enable))
    else $error("type access changed the enable");

  // other encodings on the shared port get no answer
  a_foreign_quiet: assert property ( // see RQ2
    @(posedge clk) disable iff (!rst_n)
    req.valid && sel == vcpu_hyp_pkg::SEL_NONE |=> !rsp.done)
    else $error("foreign encoding was answered");

  // a hypervisor read with the interface on is served
  a_type_el2_legal: assert property ( // see RQ12
    @(posedge clk) disable iff (!rst_n)
    sel == vcpu_hyp_pkg::SEL_TYPE && !req.write && ctx.at_el2 &&
    ctx.sysreg_enable && !trap_now |=> rsp.done && !rsp.undef && !rsp.trap)
    else $error("legal type read refused");

endmodule

// >>> hw/vcpu_hyp_params.svh
// constants for the hypervisor-facing virtual interface system registers
`ifndef VCPU_HYP_PARAMS_SVH
`define VCPU_HYP_PARAMS_SVH

// system register encoding shared by both registers
`define ENC_COPROC 4'hF
`define ENC_OPC1 3'h4
`define ENC_CRN 4'hC
`define ENC_CRM 4'hB
`define ENC_OPC2_VMC 3'h7
`define ENC_OPC2_TYPE 3'h1

// field positions of the type register
`define TYPE_PRIO_HI 31
`define TYPE_PRIO_LO 29
`define TYPE_PREEMPT_HI 28
`define TYPE_PREEMPT_LO 26
`define TYPE_INTID_HI 25
`define TYPE_INTID_LO 23
`define TYPE_SERROR_BIT 22
`define TYPE_AFF3_BIT 21
`define TYPE_NODI_BIT 20
`define TYPE_SEPTRAP_BIT 19
`define TYPE_LIST_HI 4
`define TYPE_LIST_LO 0

// field position and reset of the control register
`define VMC_GRP0_BIT 0
`define VMC_RESET 32'h0000_0000

// identifier width codes
`define INTID_CODE_16 3'h0
`define INTID_CODE_24 3'h1

// least legal priority and preemption widths
`define MIN_PRIO_BITS 5

`endif

// >>> hw/vcpu_hyp_pkg.sv
// types for the hypervisor-facing virtual interface system registers
package vcpu_hyp_pkg;

  // one system register access from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] coproc;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } sysreg_req_t;

  // privilege context of the access
  typedef struct packed {
    logic at_el2;
    logic ns_el1;
    logic hyp_trap_c12;
    logic sysreg_enable;
  } access_ctx_t;

  // answer to the core
  typedef struct packed {
    logic done;
    logic trap;
    logic undef;
    logic [31:0] rdata;
  } sysreg_rsp_t;

  // which register was selected
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_VMC,
    SEL_TYPE
  } reg_sel_t;

endpackage

// >>> hw/sysreg_decode.sv
// decoder of the system register encoding for the two registers
`include "vcpu_hyp_params.svh"

module sysreg_decode (
  // encoding in
  input wire vcpu_hyp_pkg::sysreg_req_t req,
  // selection out
  output vcpu_hyp_pkg::reg_sel_t sel
);

  // common prefix must match before opc2 picks a register
  always_comb begin
    sel = vcpu_hyp_pkg::SEL_NONE;
    if (req.valid && req.coproc == `ENC_COPROC && req.opc1 == `ENC_OPC1 &&
        req.crn == `ENC_CRN && req.crm == `ENC_CRM) begin
      if (req.opc2 == `ENC_OPC2_VMC) begin
        sel = vcpu_hyp_pkg::SEL_VMC; // see RQ2
      end else if (req.opc2 == `ENC_OPC2_TYPE) begin
        sel = vcpu_hyp_pkg::SEL_TYPE; // see RQ12
      end
    end
  end

endmodule

// >>> test/core_access_model.sv
// model of the core issuing system register accesses
module core_access_model (
  // clock
  input wire logic clk,
  // access to the block
  output vcpu_hyp_pkg::sysreg_req_t req,
  output vcpu_hyp_pkg::access_ctx_t ctx,
  // answer from the block
  input wire vcpu_hyp_pkg::sysreg_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req = '0;
    ctx = '0;
  end
  // one access on the shared encoding, opc2 picks the register
  task automatic access(input logic wr, input logic [2:0] o2,
      input logic [31:0] wd, input logic [3:0] c,
      output vcpu_hyp_pkg::sysreg_rsp_t r);
    vcpu_hyp_pkg::sysreg_req_t q;
    q = '{1'h1, wr, 4'hF, 3'h4, 4'hC, 4'hB, o2, wd};
    @(posedge clk);
    req <= q;
    ctx <= vcpu_hyp_pkg::access_ctx_t'(c);
    @(posedge clk);
    // released fields flip so a stale value never passes
    q = ~q;
    q.valid = 1'h0;
    req <= q;
    #1 r = rsp;
  endtask
endmodule

// >>> test/virt_cpu_iface_hyp_regs_tb.sv
// testbench for the hypervisor control and type registers
module virt_cpu_iface_hyp_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PRIO = 6;
  localparam int PRE = 5;
  localparam int LIST = 4;
  // non-default build except the preemption width, so a stuck field shows
  localparam logic [31:0] TYPE_EXP = {3'(PRIO - 1), 3'(PRE - 1), 3'h1,
    4'hD, 14'h0000, 5'(LIST - 1)};
  logic clk;
  logic rst_n;
  vcpu_hyp_pkg::sysreg_req_t req;
  vcpu_hyp_pkg::access_ctx_t ctx;
  vcpu_hyp_pkg::sysreg_rsp_t rsp;
  vcpu_hyp_pkg::sysreg_rsp_t r;
  logic en;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  virt_cpu_iface_hyp_regs #(.PRIO_BITS(PRIO), .PREEMPT_BITS(PRE),
    .INTID_CODE(3'h1), .SERROR_GEN(1'h1), .AFF3_VALID(1'h1),
    .NO_DIRECT_INJ(1'h0), .SEP_DEACT_TRAP(1'h1), .LIST_ENTRIES(LIST)
  ) i_dut (.clk(clk), .rst_n(rst_n), .req(req), .ctx(ctx), .rsp(rsp),
    .virt_grp0_enable(en));
  core_access_model i_core (.clk(clk), .req(req), .ctx(ctx), .rsp(rsp));
  task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // done, trap, undef packed low in one word
  function automatic logic [31:0] fl(vcpu_hyp_pkg::sysreg_rsp_t x);
    return {29'h0, x.done, x.trap, x.undef};
  endfunction
  task automatic ctrl_rw();
    i_core.access(1'h1, 3'h7, 32'hFFFF_FFFF, 4'h9, r);
    chk("wr ans", 32'h4, fl(r));
    chk("en set", 32'h1, {31'h0, en});
    i_core.access(1'h0, 3'h7, 32'h0, 4'h9, r);
    chk("ctrl rd", 32'h1, r.rdata);
    i_core.access(1'h1, 3'h7, 32'hFFFF_FFFE, 4'h9, r);
    chk("en clr", 32'h0, {31'h0, en});
    i_core.access(1'h0, 3'h7, 32'h0, 4'h9, r);
    chk("ctrl rd0", 32'h0, r.rdata);
  endtask
  // second read shows reads leave the word alone
  task automatic type_rd();
    repeat (2) begin
      i_core.access(1'h0, 3'h1, 32'h0, 4'h9, r);
      chk("type", TYPE_EXP, r.rdata);
    end
    chk("type list", 32'h1, {31'h0, r.rdata[4:0] == 5'h03});
    chk("type flags", 32'h5, {29'h0, r.rdata[21:19]});
    i_core.access(1'h1, 3'h1, 32'hFFFF_FFFF, 4'h9, r);
    chk("type wr", 32'h5, fl(r));
    i_core.access(1'h0, 3'h1, 32'h0, 4'h9, r);
    chk("type kept", TYPE_EXP, r.rdata);
  endtask
  // refused accesses: trap, undefined at EL2, undefined below EL2
  task automatic refusals();
    i_core.access(1'h1, 3'h7, 32'h1, 4'h6, r);
    chk("trap wr", 32'h6, fl(r));
    chk("en trap", 32'h0, {31'h0, en});
    i_core.access(1'h0, 3'h1, 32'h0, 4'h6, r);
    chk("trap rd", 32'h6, fl(r));
    chk("trap data", 32'h0, r.rdata);
    i_core.access(1'h1, 3'h7, 32'h1, 4'h8, r);
    chk("undef wr", 32'h5, fl(r));
    chk("en kept", 32'h0, {31'h0, en});
    i_core.access(1'h0, 3'h1, 32'h0, 4'h8, r);
    chk("undef rd", 32'h5, fl(r));
    chk("undef data", 32'h0, r.rdata);
    i_core.access(1'h0, 3'h1, 32'h0, 4'h4, r);
    chk("el1 rd", 32'h5, fl(r));
    i_core.access(1'h0, 3'h2, 32'h0, 4'h9, r);
    chk("foreign", 32'h0, fl(r));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // the run needs under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'h0;
    repeat (3) @(posedge clk);
    chk("rst en", 32'h0, {31'h0, en});
    chk("rst ans", 32'h0, fl(rsp));
    rst_n <= 1'h1;
    ctrl_rw();
    type_rd();
    refusals();
    tally_and_finish();
  end
endmodule
